// ---- design/ldsc_pkg.sv ----
/*
  ldsc_pkg: shared constants of the serial led driver control block:
  packet lengths, power-up values, status packet layout, timing counts,
  apb register map and the pwm phase type.
  assumes a 200 mhz pclk; timing counts are derived from that rate.
*/
package ldsc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // channel and packet geometry
  localparam int NCH      = 16;          // channel count
  localparam int GS_W     = 12;          // greyscale bits per channel
  localparam int DC_W     = 6;           // dot correction bits per channel
  localparam int GS_LEN   = 192;         // shift length in greyscale mode
  localparam int DC_LEN   = 96;          // shift length in dot correction mode

  // power-up values
  localparam logic [11:0] GS_RST = 12'hfff;  // greyscale 4095
  localparam logic [5:0]  DC_RST = 6'h3f;    // dot correction 63

  // status packet bit positions
  localparam int SID_OPEN_HI  = 176;     // open flags, upper copy
  localparam int SID_TERR     = 175;     // thermal error flag
  localparam int SID_TWARN    = 174;     // thermal warning flag
  localparam int SID_DC_LO    = 72;      // dot correction image, 96 bits
  localparam int SID_OPEN_LO  = 16;      // open flags, lower copy
  localparam int SID_SHORT_LO = 0;       // short flags

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS     = 5;                                 // pclk period
  localparam int SETTLE_NS  = 1000;                              // detect settle
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS; // least, round up
  localparam int STEP_NS    = 30;                                // stagger step
  localparam int STEP_CYC   = STEP_NS / CLK_NS;                  // typical step
  localparam int SPREAD_NS  = 450;                               // first to last
  localparam logic [12:0] PWM_FULL = 13'h1000;                   // 4096 pulses

  ////////////////////////////////////////////////////////////////////////
  // pin vector positions of the synchronised inputs
  localparam int PIN_SCLK  = 0;          // serial bit clock
  localparam int PIN_SIN   = 1;          // serial input
  localparam int PIN_LATCH = 2;          // latch strobe
  localparam int PIN_OD    = 3;          // output disable
  localparam int PIN_MODE  = 4;          // mode level
  localparam int PIN_PWMC  = 5;          // pwm count clock
  localparam int PIN_TERR  = 6;          // thermal error trip
  localparam int PIN_TWARN = 7;          // thermal warning trip
  localparam int PIN_OPEN  = 8;          // 16 open comparators
  localparam int PIN_SHORT = 24;         // 16 short comparators
  localparam int PIN_W     = 40;         // total synchronised width

  ////////////////////////////////////////////////////////////////////////
  // apb register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;  // control, read/write
  localparam logic [7:0] ADDR_STAT = 8'h04;  // open and short flags
  localparam logic [7:0] ADDR_FLAG = 8'h08;  // thermal, pins, pwm state
  localparam int         CTRL_DET  = 0;      // detection enable bit
  localparam int         CTRL_STAG = 1;      // stagger enable bit
  localparam logic [1:0] CTRL_RST  = 2'h3;   // both enabled at reset

  // pwm cycle phase, gray along idle, run, done
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_RUN  = 2'h1,
    PH_DONE = 2'h3
  } ldsc_phase_t;

endpackage

// ---- design/ldsc_top.sv ----
/*
  ldsc_top: control logic of a 16-channel constant-current led driver.
  serial load of greyscale or dot correction data, status readback,
  open-drain error output, thermal flags, open/short detection,
  staggered channel switching, output disable and an apb status port.
  assumes all pin inputs are asynchronous to pclk; the serial bit clock
  is much slower than pclk (at least four pclk per half period).
*/
`timescale 1ns/1ps

// Contract
// R01: shift serial input on bit clock rise
// R02: latch strobe rise copies shift register
// R03: host sends words msb first
// R04: shift register msb drives serial output
// R05: mode 0 192 bits, mode 1 96
// R06: latch updates greyscale or dot correction by mode
// R07: error output pulled low on any error
// R08: output disable masks open flags from error
// R09: disabled: error follows thermal error or warning
// R10: thermal error trip sets readable flag, error
// R11: separate lower-threshold thermal warning flag
// R12: open flag when enabled and below threshold
// R13: short flag when enabled and above threshold
// R14: detection only after settle time switched on
// R15: short flags never touch error output
// R16: open flags readable in status packet
// R17: channels staggered 30 ns steps, 450 ns
// R18: stagger applies to both on and off
// R19: output disable forces all channels off
// R20: output disable holds pwm counter reset
// R21: enabled channels follow normal pwm
// R22: power-up greyscale mode, shift register reset
// R23: greyscale latch reloads shift register with status
// R24: status packet bit layout as specified
// R25: power-up dot correction 63, greyscale 4095
module ldsc_top #(
  parameter int SETTLE_CYC = ldsc_pkg::SETTLE_CYC,  // detect settle cycles
  parameter int STEP_CYC   = ldsc_pkg::STEP_CYC     // stagger step cycles
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link pins
  input  wire logic        serial_clock,
  input  wire logic        serial_in,
  input  wire logic        latch_strobe,
  input  wire logic        mode,
  output logic             serial_out,
  // output control pins
  input  wire logic        output_disable,
  input  wire logic        pwm_count_clock,
  // error pin, open drain
  output logic             error_out_n_o,
  output logic             error_out_n_oe_n,
  // analog sense comparators
  input  wire logic        thermal_error_trip,
  input  wire logic        thermal_warn_trip,
  input  wire logic [15:0] open_below,
  input  wire logic [15:0] short_above,
  // channel drive
  output logic      [15:0] channel_output,
  output logic      [95:0] dot_correction_value
);

  ////////////////////////////////////////////////////////////////////////
  // local sizes
  // history must reach the last tap, so depth grows with
  // the step count; this is the bulk of the flops
  localparam int NCH  = ldsc_pkg::NCH;
  localparam int HD   = (NCH - 1) * STEP_CYC + 1;   // stagger history depth
  localparam int SW   = $clog2(SETTLE_CYC + 1);     // settle counter width
  localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_CYC);

  // refuse settings the logic cannot serve
  // a zero step would fold every tap onto one entry
  if (STEP_CYC < 1 || SETTLE_CYC < 1) begin : g_bad_timing
    $error("ldsc_top: step and settle counts must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // whole state of the block
  // one struct keeps every flop under one reset image
  typedef struct packed {
    logic [ldsc_pkg::PIN_W-1:0] meta;      // first sync stage, read by sync only
    logic [ldsc_pkg::PIN_W-1:0] sync;      // second sync stage
    logic                       sclk_d;    // previous bit clock
    logic                       latch_d;   // previous latch strobe
    logic                       pwmc_d;    // previous pwm clock
    logic [191:0]               sr;        // input shift register
    logic [NCH-1:0][11:0]       gs;        // greyscale values
    logic [NCH-1:0][5:0]        dc;        // dot correction values
    logic [12:0]                cnt;       // pwm counter
    ldsc_pkg::ldsc_phase_t      phase;     // pwm cycle phase
    logic [NCH-1:0]             on;        // undelayed channel state
    logic [HD-1:0][NCH-1:0]     hist;      // stagger history
    logic [NCH-1:0][SW-1:0]     settle;    // per channel on-time count
    logic [NCH-1:0]             open_f;    // open led flags
    logic [NCH-1:0]             short_f;   // shorted led flags
    logic [1:0]                 ctrl;      // detect and stagger enables
    logic [NCH-1:0]             chout;     // channel drive
    logic                       sout;      // serial output
    logic                       err_oe_n;  // error pin enable, low drives
    logic                       pready;    // apb ready
    logic                       pslverr;   // apb error
    logic [31:0]                prdata;    // apb read data
  } ldsc_state_t;

  // reset image: greyscale mode, shift register cleared, power-up data
  // empty shift register: first readback is all zero
  localparam ldsc_state_t RST = '{
    meta: '0, sync: '0, sclk_d: 1'b0, latch_d: 1'b0, pwmc_d: 1'b0,
    sr: '0,                                                         // R22
    gs: {NCH{ldsc_pkg::GS_RST}}, dc: {NCH{ldsc_pkg::DC_RST}},       // R25
    cnt: '0, phase: ldsc_pkg::PH_IDLE, on: '0, hist: '0, settle: '0,
    open_f: '0, short_f: '0, ctrl: ldsc_pkg::CTRL_RST, chout: '0,
    sout: 1'b0, err_oe_n: 1'b1, pready: 1'b0, pslverr: 1'b0, prdata: '0
  };

  ldsc_state_t s_r;   // registered state
  ldsc_state_t s_nxt; // next state

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // address is one of the three mapped words
  // other words answer with pslverr and zero data
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ldsc_pkg::ADDR_CTRL) || (a == ldsc_pkg::ADDR_STAT) ||
                  (a == ldsc_pkg::ADDR_FLAG);
  endfunction

  // assemble the status packet loaded after a greyscale latch
  // both open copies carry the same flags
  function automatic logic [191:0] status_packet(
    input logic [15:0] op,
    input logic [15:0] sh,
    input logic        te,
    input logic        tw,
    input logic [95:0] dcv
  );
    logic [191:0] p;
    p = '0;                                                         // reserved bits zero
    p[ldsc_pkg::SID_OPEN_HI +: 16]  = op;                           // R24 R16
    p[ldsc_pkg::SID_TERR]           = te;                           // R10
    p[ldsc_pkg::SID_TWARN]          = tw;                           // R11
    p[ldsc_pkg::SID_DC_LO +: 96]    = dcv;                          // R24
    p[ldsc_pkg::SID_OPEN_LO +: 16]  = op;                           // R16
    p[ldsc_pkg::SID_SHORT_LO +: 16] = sh;                           // R15
    status_packet = p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic        sclk;     // synced bit clock
    logic        sin;      // synced serial data
    logic        od;       // synced output disable
    logic        md;       // synced mode
    logic        te;       // synced thermal error
    logic        tw;       // synced thermal warning
    logic [12:0] cnt_new;  // counter after a pwm pulse
    logic        tap;      // delayed channel state
    logic        drive;    // error pin pulled low
    sclk    = s_r.sync[ldsc_pkg::PIN_SCLK];
    sin     = s_r.sync[ldsc_pkg::PIN_SIN];
    od      = s_r.sync[ldsc_pkg::PIN_OD];
    md      = s_r.sync[ldsc_pkg::PIN_MODE];
    te      = s_r.sync[ldsc_pkg::PIN_TERR];
    tw      = s_r.sync[ldsc_pkg::PIN_TWARN];
    cnt_new = s_r.cnt + 13'h1;
    tap     = 1'b0;
    drive   = 1'b0;
    s_nxt   = s_r;

    // two-flop synchronisers on every pin input
    // pins are read as single levels or edges, never as
    // a word, so skew between synchronisers is harmless
    s_nxt.meta = {short_above, open_below, thermal_warn_trip, thermal_error_trip,
                  pwm_count_clock, mode, output_disable, latch_strobe,
                  serial_in, serial_clock};
    s_nxt.sync    = s_r.meta;
    s_nxt.sclk_d  = sclk;
    s_nxt.latch_d = s_r.sync[ldsc_pkg::PIN_LATCH];
    s_nxt.pwmc_d  = s_r.sync[ldsc_pkg::PIN_PWMC];

    // serial shift; latch takes the register as it stood before
    // a latch beats a bit clock edge in one cycle and the
    // bit is lost; the host keeps the two well apart
    if (s_r.sync[ldsc_pkg::PIN_LATCH] && !s_r.latch_d) begin
      if (!md) begin
        for (int c = 0; c < NCH; c++) begin
          s_nxt.gs[c] = s_r.sr[c*ldsc_pkg::GS_W +: ldsc_pkg::GS_W];   // R02 R06
        end
        s_nxt.sr = status_packet(s_r.open_f, s_r.short_f, te, tw, s_r.dc); // R23
      end else begin
        for (int c = 0; c < NCH; c++) begin
          s_nxt.dc[c] = s_r.sr[c*ldsc_pkg::DC_W +: ldsc_pkg::DC_W];   // R06
        end
      end
    end else if (sclk && !s_r.sclk_d) begin
      // first bit in ends at the top, so msb-first words land in place
      if (!md) begin
        s_nxt.sr = {s_r.sr[190:0], sin};                              // R01 R05 R03
      end else begin
        s_nxt.sr[95:0] = {s_r.sr[94:0], sin};                         // R05
      end
    end

    // serial output taps the end of the active length
    // lags the shift by one pclk, well inside a bit
    s_nxt.sout = md ? s_r.sr[ldsc_pkg::DC_LEN-1] : s_r.sr[ldsc_pkg::GS_LEN-1]; // R04

    // pwm counter and undelayed channel states
    // runs only with disable low; after a full cycle it
    // parks until disable is raised and dropped again
    if (od) begin
      s_nxt.cnt   = '0;                                               // R20
      s_nxt.phase = ldsc_pkg::PH_IDLE;
      s_nxt.on    = '0;
    end else if (s_r.sync[ldsc_pkg::PIN_PWMC] && !s_r.pwmc_d) begin
      case (s_r.phase)
        ldsc_pkg::PH_IDLE: begin
          // first pulse after enable: start cycle
          s_nxt.cnt   = cnt_new;
          s_nxt.phase = ldsc_pkg::PH_RUN;
          for (int c = 0; c < NCH; c++) begin
            s_nxt.on[c] = (s_r.gs[c] != 12'h000) && (s_r.gs[c] != cnt_new[11:0]); // R21
          end
        end
        ldsc_pkg::PH_RUN: begin
          // channels go off when the counter reaches their value
          s_nxt.cnt = cnt_new;
          if (cnt_new == ldsc_pkg::PWM_FULL) begin
            s_nxt.phase = ldsc_pkg::PH_DONE;
            s_nxt.on    = '0;
          end else begin
            for (int c = 0; c < NCH; c++) begin
              if (s_r.gs[c] == cnt_new[11:0]) begin
                s_nxt.on[c] = 1'b0;                                   // R21
              end
            end
          end
        end
        ldsc_pkg::PH_DONE: begin
          // wait for output disable to restart
          s_nxt.on = '0;
        end
        default: begin
          s_nxt.phase = ldsc_pkg::PH_IDLE;
          s_nxt.on    = '0;
        end
      endcase
    end

    // stagger line: one delay serves both edges, so on-time is kept
    // trade-off: a shift line costs flops but keeps
    // on-time exact, where two timers could drift apart
    s_nxt.hist = {s_r.hist[HD-2:0], s_r.on};                          // R17 R18
    for (int c = 0; c < NCH; c++) begin
      tap = s_r.ctrl[ldsc_pkg::CTRL_STAG] ? s_r.hist[c*STEP_CYC][c]
                                          : s_r.hist[0][c];           // R17
      // disable cuts the drive at once, not through the delay line
      s_nxt.chout[c] = tap && !od;                                    // R19
    end

    // open/short sampling once per on period after settling
    // a flag is a measurement: held while off, rewritten
    // only by the next settled sample, never by software
    for (int c = 0; c < NCH; c++) begin
      if (!s_r.chout[c]) begin
        s_nxt.settle[c] = '0;
      end else if (s_r.settle[c] != SETTLE_END) begin
        s_nxt.settle[c] = s_r.settle[c] + SW'(1);                     // R14
        if (s_r.settle[c] == SETTLE_END - SW'(1) && s_r.ctrl[ldsc_pkg::CTRL_DET]) begin
          s_nxt.open_f[c]  = s_r.sync[ldsc_pkg::PIN_OPEN + c];        // R12
          s_nxt.short_f[c] = s_r.sync[ldsc_pkg::PIN_SHORT + c];       // R13
        end
      end
    end

    // error pin: shorts never contribute
    // disable splits the thermal causes from open leds
    if (od) begin
      drive = md ? tw : te;                                           // R08 R09
    end else begin
      drive = te || (|s_r.open_f);                                    // R07 R10 R12 R15
    end
    s_nxt.err_oe_n = !drive;                                          // R07

    // apb: answer prepared in setup, taken in the single access cycle
    // zero wait states: pready registered from setup, so
    // every transfer takes exactly two pclk
    s_nxt.pready  = psel && !penable;
    s_nxt.pslverr = psel && !penable && !addr_mapped(paddr);
    s_nxt.prdata  = '0;
    if (psel && !penable) begin
      case (paddr)
        ldsc_pkg::ADDR_CTRL: s_nxt.prdata = {30'h0, s_r.ctrl};
        ldsc_pkg::ADDR_STAT: s_nxt.prdata = {s_r.short_f, s_r.open_f}; // R16
        ldsc_pkg::ADDR_FLAG: s_nxt.prdata = {13'h0, s_r.cnt, s_r.phase, od, md, tw, te}; // R10 R11
        default:             s_nxt.prdata = '0;
      endcase
    end
    if (psel && penable && s_r.pready && pwrite && paddr == ldsc_pkg::ADDR_CTRL) begin
      s_nxt.ctrl = pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  // the only clocked process; reset loads the whole image
  // every reset value is a constant, so mid-run reset is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  // error pin data is a constant low; only its enable moves
  // enable low means the pin is pulled low
  assign prdata               = s_r.prdata;
  assign pready               = s_r.pready;
  assign pslverr              = s_r.pslverr;
  assign serial_out           = s_r.sout;
  assign error_out_n_o        = 1'b0 & s_r.err_oe_n;  // pin only ever pulled low
  assign error_out_n_oe_n     = s_r.err_oe_n;
  assign channel_output       = s_r.chout;
  assign dot_correction_value = s_r.dc;

endmodule

// ---- dv/ldsc_asserts.sv ----
/*
  ldsc_asserts: port-level checker for ldsc_top, bound to every instance.
  assumes one pclk domain and that presetn is asynchronous, active low.
*/
`timescale 1ns/1ps
module ldsc_asserts #(
  parameter int STEP_CYC = 1   // stagger step, handed on by the bind
) (
  // clock, reset and apb answer
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin levels
  input wire logic        mode,
  input wire logic        output_disable,
  input wire logic        thermal_error_trip,
  input wire logic        thermal_warn_trip,
  input wire logic        error_out_n_o,
  input wire logic        error_out_n_oe_n,
  input wire logic [15:0] channel_output,
  input wire logic [95:0] dot_correction_value
);
  // sync, edge detect and the last stagger tap all fit inside this
  localparam int OD_LAT = 6 + 15 * STEP_CYC;
  logic [7:0] od_cnt_r;  // cycles with output disable held high
  logic       in_rst_r;  // reset seen at the previous edge

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  // saturating count of disable time, cleared as soon as it drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) od_cnt_r <= 8'h0;
    else if (!output_disable) od_cnt_r <= 8'h0;
    else if (od_cnt_r != 8'hff) od_cnt_r <= od_cnt_r + 8'h1;
  end

  // reset level one edge back; unknown before the first edge
  always_ff @(posedge pclk) in_rst_r <= !presetn;

  ////////////////////////////////////////////////////////////////////////
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  apb_err_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  pin_low_a: assert property (error_out_n_o == 1'b0)
    else $error("error pin data not low");
  terr_pin_a: assert property ((!output_disable && thermal_error_trip) [*8]
    |-> !error_out_n_oe_n) else $error("thermal error not on pin");
  open_mask_a: assert property ((output_disable && !mode && !thermal_error_trip) [*8]
    |-> error_out_n_oe_n) else $error("open flag not masked");
  warn_pin_a: assert property ((output_disable && mode && $stable(thermal_warn_trip)) [*8]
    |-> error_out_n_oe_n == !thermal_warn_trip) else $error("pin not following warning");
  od_off_a: assert property (od_cnt_r >= OD_LAT |-> channel_output == 16'h0)
    else $error("channel on while disabled");
  dc_hold_a: assert property ((!mode) [*8] |=> $stable(dot_correction_value))
    else $error("dot correction changed in greyscale mode");
  dc_reset_a: assert property (disable iff (1'b0) !presetn && in_rst_r
    |-> dot_correction_value == {16{ldsc_pkg::DC_RST}}) else $error("dot correction reset");
endmodule

bind ldsc_top ldsc_asserts #(.STEP_CYC(STEP_CYC)) ldsc_asserts_inst (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .mode, .output_disable,
  .thermal_error_trip, .thermal_warn_trip, .error_out_n_o, .error_out_n_oe_n,
  .channel_output, .dot_correction_value);

// ---- dv/ldsc_host.sv ----
/*
  ldsc_host: behavioural serial host driving the link pins of ldsc_top.
  assumes it alone drives the serial pins; bit clock period 125 ns.
*/
`timescale 1ns/1ps
module ldsc_host (
  // link pins toward the device
  output logic      serial_clock,
  output logic      serial_in,
  output logic      latch_strobe,
  // readback from the device
  input  wire logic serial_out
);
  // bit clock idles low and stands still between frames
  initial begin
    serial_clock = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame of n bits, msb first, then a latch; rd gets serial_out
  task automatic send(input logic [191:0] d, input int n, output logic [191:0] rd);
    rd = '0;
    #1.3;  // keeps link edges off the pclk grid
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = d[i];
      #62.5;
      rd[i] = serial_out;
      serial_clock = 1'b1;
      #62.5;
      serial_clock = 1'b0;
    end
    serial_in = ~d[0];  // stale level must not look held
    #62.5;
    latch_strobe = 1'b1;
    #125;
    latch_strobe = 1'b0;
    #125;
  endtask
endmodule

// ---- dv/led_driver_serial_ctrl_err_test.sv ----
/*
  led_driver_serial_ctrl_err_test: directed bench for ldsc_top, apb tasks
  plus a serial host. assumes short settle and step parameters (4 and 1).
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module led_driver_serial_ctrl_err_test;
  logic         pclk = 1'b0, presetn = 1'b0;          // clock, reset
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h0;                         // apb address
  logic [31:0]  pwdata = 32'h0, prdata, rd;           // apb data
  logic         pready, pslverr, er, serial_out;
  logic         mode = 1'b0, od = 1'b1, pwmc = 1'b0;  // control pins
  logic         terr = 1'b0, twarn = 1'b0, err_o, err_oe_n;
  logic [15:0]  open_below = 16'h0, short_above = 16'h0, chan;
  logic [95:0]  dcv;
  logic [191:0] back;                                 // serial readback
  wire          sclk, sin, latch;
  wire          err_pin = err_oe_n ? 1'b1 : err_o;    // pull-up on the wire
  int           n_errors = 0, n_tests = 0;
  localparam logic [95:0]  DCP = 96'h0c3_5a9_f21_7e4_b86_d10_2af_963;
  localparam logic [191:0] GSP = {16{12'h5a3}};

  always #2.5 pclk = ~pclk;

  ldsc_top #(.SETTLE_CYC(4), .STEP_CYC(1)) ldsc_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_clock(sclk), .serial_in(sin), .latch_strobe(latch), .mode,
    .serial_out, .output_disable(od), .pwm_count_clock(pwmc), .error_out_n_o(err_o),
    .error_out_n_oe_n(err_oe_n), .thermal_error_trip(terr), .thermal_warn_trip(twarn),
    .open_below, .short_above, .channel_output(chan), .dot_correction_value(dcv));
  ldsc_host ldsc_host_inst (.serial_clock(sclk), .serial_in(sin),
    .latch_strobe(latch), .serial_out);

  ////////////////////////////////////////////////////////////////////////
  // one apb transfer; answer taken at the rising edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pwm count clock pulses, eight pclk each
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      pwmc <= 1'b1;
      repeat (4) @(posedge pclk);
      pwmc <= 1'b0;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard, well past the four serial frames
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("dc reset", {16{ldsc_pkg::DC_RST}}, dcv)
    `CHK("sout reset", 1'b0, serial_out)
    apb(1'b0, ldsc_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h3, rd)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, ldsc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, ldsc_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl write", 32'h0, rd)
    apb(1'b1, ldsc_pkg::ADDR_CTRL, 32'h3);
    // channels on with comparators tripped, detection enabled
    open_below <= 16'ha5a5;
    short_above <= 16'h0f0f;
    od <= 1'b0;
    pulses(3);
    repeat (40) @(posedge pclk);
    `CHK("chan on", 16'hffff, chan)
    apb(1'b0, ldsc_pkg::ADDR_STAT, 32'h0);
    `CHK("flags", 32'h0f0fa5a5, rd)
    `CHK("open pin", 1'b0, err_pin)
    apb(1'b0, ldsc_pkg::ADDR_FLAG, 32'h0);
    `CHK("pwm count", 13'h3, rd[18:6])
    // dot correction frames; the second pushes the first out
    mode <= 1'b1;
    repeat (10) @(posedge pclk);
    ldsc_host_inst.send({96'h0, DCP}, 96, back);
    repeat (10) @(posedge pclk);
    `CHK("dc load", DCP, dcv)
    ldsc_host_inst.send({96'h0, ~DCP}, 96, back);
    `CHK("dc cascade", DCP, back[95:0])
    `CHK("dc load 2", ~DCP, dcv)
    @(posedge pclk);
    // greyscale frames; the second reads the status packet back
    mode <= 1'b0;
    repeat (10) @(posedge pclk);
    ldsc_host_inst.send(GSP, 192, back);
    ldsc_host_inst.send(GSP, 192, back);
    `CHK("status", {16'ha5a5, 8'h0, ~DCP, 40'h0, 32'ha5a50f0f}, back)
    @(posedge pclk);
    // disable: outputs off, counter cleared, open flags masked
    od <= 1'b1;
    repeat (30) @(posedge pclk);
    `CHK("chan off", 16'h0, chan)
    `CHK("masked", 1'b1, err_pin)
    apb(1'b0, ldsc_pkg::ADDR_FLAG, 32'h0);
    `CHK("pwm reset", 16'h0001, rd[18:3])
    // every mode and thermal combination while disabled
    for (int i = 0; i < 8; i++) begin
      {mode, terr, twarn} <= i[2:0];
      repeat (10) @(posedge pclk);
      `CHK("err pin", i[2] ? !i[0] : !i[1], err_pin)
    end
    mode <= 1'b0;
    od <= 1'b0;
    open_below <= 16'h0;
    short_above <= 16'h0;
    pulses(1);
    repeat (40) @(posedge pclk);
    apb(1'b0, ldsc_pkg::ADDR_STAT, 32'h0);
    `CHK("flags clear", 32'h0, rd)
    `CHK("terr pin", 1'b0, err_pin)
    apb(1'b0, ldsc_pkg::ADDR_FLAG, 32'h0);
    `CHK("thermal flags", 2'h3, rd[1:0])
    report_and_stop();
  end
endmodule
